// ===== hw/nop_or_regs.vh
// Constants for the idle and bitwise OR instruction executor.
`ifndef NOR_OR_REGS_VH
`define NOR_OR_REGS_VH
`define NOR_OP_IDLE 8'h00
`define NOR_OP_OR_IMM 8'h44
`define NOR_OP_OR_IND 7'h23
`define NOR_OP_OR_REG 5'h09
`define NOR_OP_OR_DIR 8'h45
`define NOR_OP_OR_BIT 8'h72
`define NOR_OP_OR_NBIT 8'ha0
`define NOR_OP_OR_MEM_IMM 8'h43
`define NOR_OP_OR_MEM_ACC 8'h42
`define NOR_RESET_PC 16'h0000
`define NOR_RESET_ACC 8'h00
`endif

// ===== hw/nor_exec.v
// Fetch, decode and execute core for the idle and bitwise OR instructions.
`timescale 1ns/1ps
`include "nop_or_regs.vh"

module nor_exec #(
  parameter DATA_DEPTH = 256
) (
  input wire CLK_SYS_IN,
  input wire RESETN_IN,
  input wire [7:0] CODE_DATA_IN,
  output reg [15:0] CODE_ADDR_OUT,
  output reg [7:0] ACC_OUT,
  output reg CARRY_OUT,
  output reg INSTR_DONE_OUT,
  output reg ILLEGAL_OUT
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  localparam [4:0] ST_FETCH = 5'b00001;
  localparam [4:0] ST_OPND1 = 5'b00010;
  localparam [4:0] ST_OPND2 = 5'b00100;
  localparam [4:0] ST_EXEC = 5'b01000;
  localparam [4:0] ST_EXEC2 = 5'b10000;

  // Internal data memory; the working registers live in bytes 0 to 7.
  reg [7:0] data_mem [0:DATA_DEPTH-1];
  reg [4:0] state;
  reg [7:0] opcode;
  reg [7:0] opnd1;
  reg [7:0] opnd2;
  reg [15:0] pc;
  reg [7:0] acc;
  reg carry;
  integer i;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Bit address to byte address: low half in 20h-2fh, high half in 80h+ byte groups.
  function [7:0] bit_byte;
    input [7:0] baddr;
    begin
      if (baddr[7]) begin
        bit_byte = {baddr[7:3], 3'b000};
      end else begin
        bit_byte = 8'h20 + {4'h0, baddr[6:3]};
      end
    end
  endfunction

  function [7:0] mem_rd;
    input [7:0] addr;
    begin
      mem_rd = data_mem[addr];
    end
  endfunction

  // Reads one addressable bit at the clock edge, so a memory write made at that same edge is not seen.
  function bit_rd;
    input [7:0] baddr;
    reg [7:0] byte_val;
    begin
      byte_val = mem_rd(bit_byte(baddr));
      bit_rd = byte_val[baddr[2:0]];
    end
  endfunction

  // Indirect form: the low opcode bit picks pointer register 0 or 1.
  function is_ind;
    input [7:0] op;
    begin
      is_ind = (op[7:1] == `NOR_OP_OR_IND);
    end
  endfunction

  // Register form: the low three opcode bits pick one of eight working registers.
  function is_reg;
    input [7:0] op;
    begin
      is_reg = (op[7:3] == `NOR_OP_OR_REG);
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode of operand count
  // ----------------------------------------------------------------
  reg [1:0] opnd_count;
  reg known;
  always @* begin
    known = 1'b1;
    opnd_count = 2'd0;
    if (CODE_DATA_IN == `NOR_OP_OR_MEM_IMM) begin
      opnd_count = 2'd2;
    end else if (CODE_DATA_IN == `NOR_OP_OR_IMM || CODE_DATA_IN == `NOR_OP_OR_DIR ||
                 CODE_DATA_IN == `NOR_OP_OR_BIT || CODE_DATA_IN == `NOR_OP_OR_NBIT ||
                 CODE_DATA_IN == `NOR_OP_OR_MEM_ACC) begin
      opnd_count = 2'd1;
    end else if (CODE_DATA_IN == `NOR_OP_IDLE || is_ind(CODE_DATA_IN) || is_reg(CODE_DATA_IN)) begin
      opnd_count = 2'd0;
    end else begin
      known = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and datapath
  // ----------------------------------------------------------------
  // The fetch address is kept in its own flip-flop beside the counter, so the port never sees an adder.
  always @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      state <= ST_FETCH;
      opcode <= 8'h00;
      opnd1 <= 8'h00;
      opnd2 <= 8'h00;
      pc <= `NOR_RESET_PC;
      acc <= `NOR_RESET_ACC;
      carry <= 1'b0;
      CODE_ADDR_OUT <= `NOR_RESET_PC;
      ACC_OUT <= `NOR_RESET_ACC;
      CARRY_OUT <= 1'b0;
      INSTR_DONE_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      for (i = 0; i < DATA_DEPTH; i = i + 1) begin
        data_mem[i] <= 8'h00;
      end
    end else begin
      INSTR_DONE_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      case (state)
        ST_FETCH: begin
          opcode <= CODE_DATA_IN;
          pc <= pc + 16'h0001;
          CODE_ADDR_OUT <= pc + 16'h0001;
          if (!known) begin
            ILLEGAL_OUT <= 1'b1;
            INSTR_DONE_OUT <= 1'b1;
          end else if (opnd_count == 2'd0) begin
            INSTR_DONE_OUT <= 1'b1;
            if (is_ind(CODE_DATA_IN)) begin
              acc <= acc | mem_rd(mem_rd({7'h00, CODE_DATA_IN[0]}));
              ACC_OUT <= acc | mem_rd(mem_rd({7'h00, CODE_DATA_IN[0]}));
            end else if (is_reg(CODE_DATA_IN)) begin
              acc <= acc | mem_rd({5'h00, CODE_DATA_IN[2:0]});
              ACC_OUT <= acc | mem_rd({5'h00, CODE_DATA_IN[2:0]});
            end
            // The idle opcode falls through with nothing changed.
          end else begin
            state <= ST_OPND1;
          end
        end
        ST_OPND1: begin
          opnd1 <= CODE_DATA_IN;
          pc <= pc + 16'h0001;
          CODE_ADDR_OUT <= pc + 16'h0001;
          state <= (opcode == `NOR_OP_OR_MEM_IMM) ? ST_OPND2 : ST_EXEC;
        end
        ST_OPND2: begin
          opnd2 <= CODE_DATA_IN;
          pc <= pc + 16'h0001;
          CODE_ADDR_OUT <= pc + 16'h0001;
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          state <= ST_FETCH;
          INSTR_DONE_OUT <= 1'b1;
          case (opcode)
            `NOR_OP_OR_IMM: begin
              acc <= acc | opnd1;
              ACC_OUT <= acc | opnd1;
            end
            `NOR_OP_OR_DIR: begin
              acc <= acc | mem_rd(opnd1);
              ACC_OUT <= acc | mem_rd(opnd1);
            end
            `NOR_OP_OR_MEM_ACC: begin
              data_mem[opnd1] <= mem_rd(opnd1) | acc;
            end
            `NOR_OP_OR_MEM_IMM: begin
              data_mem[opnd1] <= mem_rd(opnd1) | opnd2;
              INSTR_DONE_OUT <= 1'b0;
              state <= ST_EXEC2;
            end
            `NOR_OP_OR_BIT, `NOR_OP_OR_NBIT: begin
              INSTR_DONE_OUT <= 1'b0;
              state <= ST_EXEC2;
            end
            default: begin
              ILLEGAL_OUT <= 1'b1;
            end
          endcase
        end
        ST_EXEC2: begin
          // Second machine cycle of the two-cycle forms.
          state <= ST_FETCH;
          INSTR_DONE_OUT <= 1'b1;
          if (opcode == `NOR_OP_OR_BIT) begin
            carry <= carry | bit_rd(opnd1);
            CARRY_OUT <= carry | bit_rd(opnd1);
          end else if (opcode == `NOR_OP_OR_NBIT) begin
            // Only the operand path is inverted; memory is not written.
            carry <= carry | ~bit_rd(opnd1);
            CARRY_OUT <= carry | ~bit_rd(opnd1);
          end
        end
        default: begin
          state <= ST_FETCH;
        end
      endcase
    end
  end
endmodule // nor_exec

// ===== tb/nor_exec_chk.sv
// Checker for the idle and bitwise OR executor.
`timescale 1ns/1ps
module nor_exec_chk (
  input wire CLK_SYS_IN,
  input wire RESETN_IN,
  input wire [7:0] CODE_DATA_IN,
  input wire [15:0] CODE_ADDR_OUT,
  input wire [7:0] ACC_OUT,
  input wire CARRY_OUT,
  input wire INSTR_DONE_OUT,
  input wire ILLEGAL_OUT
);
  // High in each cycle whose code byte is an opcode: the first after reset or after a finished instruction.
  reg after_reset;
  wire fetch;
  always @(posedge CLK_SYS_IN) begin
    after_reset <= !RESETN_IN;
  end
  assign fetch = after_reset || INSTR_DONE_OUT;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESETN_IN);
  a_idle_step: assert property (fetch && CODE_DATA_IN == 8'h00
    |=> INSTR_DONE_OUT && $stable(ACC_OUT) && $stable(CARRY_OUT)
    && CODE_ADDR_OUT == $past(CODE_ADDR_OUT) + 16'h1) else $error("idle step wrong");
  a_imm_acc: assert property (fetch && CODE_DATA_IN == 8'h44
    |=> ##2 INSTR_DONE_OUT
    && ACC_OUT == ($past(ACC_OUT, 3) | $past(CODE_DATA_IN, 2))) else $error("immediate or wrong");
  a_ind_acc: assert property (fetch && CODE_DATA_IN[7:1] == 7'h23
    |=> INSTR_DONE_OUT && (ACC_OUT & $past(ACC_OUT)) == $past(ACC_OUT) && $stable(CARRY_OUT)
    && CODE_ADDR_OUT == $past(CODE_ADDR_OUT) + 16'h1) else $error("indirect or wrong");
  a_reg_acc: assert property (fetch && CODE_DATA_IN[7:3] == 5'h09
    |=> INSTR_DONE_OUT && (ACC_OUT & $past(ACC_OUT)) == $past(ACC_OUT) && $stable(CARRY_OUT)
    && CODE_ADDR_OUT == $past(CODE_ADDR_OUT) + 16'h1) else $error("register or wrong");
  a_dir_acc: assert property (fetch && CODE_DATA_IN == 8'h45
    |=> !INSTR_DONE_OUT ##1 !INSTR_DONE_OUT
    ##1 INSTR_DONE_OUT && (ACC_OUT & $past(ACC_OUT, 3)) == $past(ACC_OUT, 3)) else $error("direct or wrong");
  a_bit_carry: assert property (fetch && CODE_DATA_IN == 8'h72
    |=> !INSTR_DONE_OUT [*3]
    ##1 INSTR_DONE_OUT && (CARRY_OUT || !$past(CARRY_OUT, 4))) else $error("bit or wrong");
  a_nbit_carry: assert property (fetch && CODE_DATA_IN == 8'ha0
    |=> !INSTR_DONE_OUT [*3]
    ##1 INSTR_DONE_OUT && $stable(ACC_OUT) && (CARRY_OUT || !$past(CARRY_OUT, 4))) else $error("nbit or wrong");
  a_mem_imm: assert property (fetch && CODE_DATA_IN == 8'h43
    |=> !INSTR_DONE_OUT [*4]
    ##1 INSTR_DONE_OUT && $stable(ACC_OUT)) else $error("memory immediate timing wrong");
  a_mem_acc: assert property (fetch && CODE_DATA_IN == 8'h42
    |=> !INSTR_DONE_OUT ##1 !INSTR_DONE_OUT
    ##1 INSTR_DONE_OUT && $stable(ACC_OUT) && CODE_ADDR_OUT == $past(CODE_ADDR_OUT, 3) + 16'h2)
    else $error("memory accumulator or wrong");
  a_pc_order: assert property (fetch && CODE_DATA_IN == 8'h43
    |=> CODE_ADDR_OUT == $past(CODE_ADDR_OUT) + 16'h1
    ##1 CODE_ADDR_OUT == $past(CODE_ADDR_OUT, 2) + 16'h2
    ##1 CODE_ADDR_OUT == $past(CODE_ADDR_OUT, 3) + 16'h3) else $error("operand order wrong");
  a_refused_op: assert property (ILLEGAL_OUT
    |-> INSTR_DONE_OUT && $stable(ACC_OUT) && $stable(CARRY_OUT)
    && CODE_ADDR_OUT == $past(CODE_ADDR_OUT) + 16'h1) else $error("refused opcode wrong");
endmodule // nor_exec_chk
bind nor_exec nor_exec_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN), .CODE_DATA_IN(CODE_DATA_IN),
  .CODE_ADDR_OUT(CODE_ADDR_OUT), .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT), .INSTR_DONE_OUT(INSTR_DONE_OUT),
  .ILLEGAL_OUT(ILLEGAL_OUT));

// ===== tb/testbench.sv
// Self-checking bench for the idle and bitwise OR executor.
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] code_in = 8'h00;
  wire [15:0] code_addr;
  wire [7:0] acc;
  wire carry;
  wire done;
  wire illegal;
  integer err_count = 0;
  integer n_compared = 0;
  integer i;
  always #10 clk_sys = ~clk_sys;
  nor_exec dut (.CLK_SYS_IN(clk_sys), .RESETN_IN(resetn), .CODE_DATA_IN(code_in),
    .CODE_ADDR_OUT(code_addr), .ACC_OUT(acc), .CARRY_OUT(carry), .INSTR_DONE_OUT(done), .ILLEGAL_OUT(illegal));
  task check(input string what, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
        err_count = err_count + 1;
      end
    end
  endtask
  // Runs one instruction; the bench is the code memory and drives each byte at the falling edge.
  task step(input [23:0] code, input integer len, input integer edges, input [7:0] e_acc, input e_c);
    reg [15:0] pc;
    reg [23:0] rest;
    begin
      pc = code_addr;
      code_in = code[23:16];
      for (i = 1; i <= edges; i = i + 1) begin
        @(negedge clk_sys);
        check("done", i == edges, done);
        rest = code << (8 * (code_addr - pc));
        if (i < edges) code_in = (code_addr - pc < len) ? rest[23:16] : 8'h00;
      end
      check("pc", pc + len[15:0], code_addr);
      check("acc", e_acc, acc);
      check("carry", e_c, carry);
    end
  endtask
  task sc_idle;
    step(24'h000000, 1, 1, 8'h00, 1'b0);
  endtask
  task sc_acc;
    begin
      step(24'h440100, 2, 3, 8'h01, 1'b0);
      step(24'h431080, 3, 5, 8'h01, 1'b0);
      step(24'h421000, 2, 3, 8'h01, 1'b0);
      step(24'h451000, 2, 3, 8'h81, 1'b0);
    end
  endtask
  task sc_regs;
    begin
      step(24'h430440, 3, 5, 8'h81, 1'b0);
      step(24'h4c0000, 1, 1, 8'hc1, 1'b0);
      step(24'h430006, 3, 5, 8'hc1, 1'b0);
      step(24'h430602, 3, 5, 8'hc1, 1'b0);
      step(24'h460000, 1, 1, 8'hc3, 1'b0);
    end
  endtask
  task sc_carry;
    begin
      step(24'h720a00, 2, 4, 8'hc3, 1'b0);
      step(24'h432104, 3, 5, 8'hc3, 1'b0);
      step(24'ha00a00, 2, 4, 8'hc3, 1'b0);
      step(24'h720a00, 2, 4, 8'hc3, 1'b1);
      step(24'h010000, 1, 1, 8'hc3, 1'b1);
      check("illegal", 1, illegal);
      step(24'h452100, 2, 3, 8'hc7, 1'b1);
    end
  endtask
  // A reset in mid-run clears the outputs and the data memory and restarts at address zero.
  task sc_reset;
    begin
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      check("pc", 16'h0000, code_addr);
      check("acc", 16'h0000, acc);
      check("carry", 16'h0000, carry);
      check("done", 16'h0000, done);
      step(24'ha00a00, 2, 4, 8'h00, 1'b1);
      step(24'h451000, 2, 3, 8'h00, 1'b1);
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    sc_idle;
    sc_acc;
    sc_regs;
    sc_carry;
    sc_reset;
    conclude;
  end
  initial begin
    #100000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // testbench
